// File: design/ssf_slave_rx.sv
// Two-wire slave listener: address, command and data match events
`timescale 1ns/1ps

module ssf_slave_rx (
    input  wire logic       clk,          // System clock
    input  wire logic       arst_n,       // Async reset
    input  wire logic       scl,          // Synchronised bus clock
    input  wire logic       sda,          // Synchronised bus data
    output logic            sda_o,        // Data pin output value
    output logic            sda_oe,       // Data pin drive enable
    input  wire logic [6:0] shadow1_addr, // First shadow address
    input  wire logic [6:0] shadow2_addr, // Second shadow address
    input  wire logic [6:0] own_addr,     // Own slave address
    input  wire logic [7:0] cmd_match,    // Command match value
    input  wire logic [7:0] data_pattern, // Data event pattern
    output logic            hit1,         // Pulse: shadow port 1 match
    output logic            hit2,         // Pulse: shadow port 2 match
    output logic            evt,          // Pulse: command and data match
    output logic            rx_busy       // Level: receiving data
);

    ssf_pkg::ssf_rx_state_type state_q;
    logic       scl_q;
    logic       sda_q;
    logic [2:0] bit_q;
    logic [1:0] idx_q;
    logic [6:0] shift_q;
    logic [7:0] cmd_q;
    logic       own_q;
    logic       start_c;
    logic       stop_c;
    logic       rise_c;
    logic       fall_c;
    logic [7:0] byte_c;

    assign start_c = scl && scl_q && sda_q && !sda;
    assign stop_c  = scl && scl_q && !sda_q && sda;
    assign rise_c  = scl && !scl_q;
    assign fall_c  = !scl && scl_q;
    assign byte_c  = {shift_q, sda};
    // Open-drain: only ever pulls low
    assign sda_o   = 1'b0;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ssf_pkg::RX_IDLE;
            bit_q   <= 3'h0;
            idx_q   <= 2'h0;
            shift_q <= 7'h00;
            cmd_q   <= 8'h00;
            own_q   <= 1'b0;
            sda_oe  <= 1'b0;
            hit1    <= 1'b0;
            hit2    <= 1'b0;
            evt     <= 1'b0;
            rx_busy <= 1'b0;
        end
        else
        begin
            hit1 <= 1'b0;
            hit2 <= 1'b0;
            evt  <= 1'b0;
            if (start_c)
            begin
                state_q <= ssf_pkg::RX_BYTE;
                bit_q   <= 3'h0;
                idx_q   <= 2'h0;
                own_q   <= 1'b0;
                sda_oe  <= 1'b0;
                rx_busy <= 1'b0;
            end
            else if (stop_c)
            begin
                state_q <= ssf_pkg::RX_IDLE;
                sda_oe  <= 1'b0;
                rx_busy <= 1'b0;
            end
            else
            begin
                case (state_q)
                    ssf_pkg::RX_BYTE:
                    begin
                        if (rise_c)
                        begin
                            shift_q <= byte_c[6:0];
                            bit_q   <= bit_q + 3'h1;
                            if (bit_q == 3'h7)
                            begin
                                state_q <= ssf_pkg::RX_ACK;
                                if (idx_q == 2'h0)
                                begin
                                    hit1    <= (byte_c[7:1] == shadow1_addr);
                                    hit2    <= (byte_c[7:1] == shadow2_addr);
                                    own_q   <= (byte_c[7:1] == own_addr);
                                    rx_busy <= 1'b1;
                                    // Reads would need a transmitter; they are not claimed
                                    if (byte_c[0] || !((byte_c[7:1] == shadow1_addr)
                                        || (byte_c[7:1] == shadow2_addr)
                                        || (byte_c[7:1] == own_addr)))
                                    begin
                                        state_q <= ssf_pkg::RX_SKIP;
                                        rx_busy <= 1'b0;
                                    end
                                end
                                else if (idx_q == 2'h1)
                                begin
                                    cmd_q <= byte_c;
                                end
                                else
                                begin
                                    evt <= own_q && (cmd_q == cmd_match)
                                        && ((byte_c & data_pattern) != 8'h00);
                                end
                            end
                        end
                    end
                    ssf_pkg::RX_ACK:
                    begin
                        if (fall_c)
                        begin
                            sda_oe <= !sda_oe;
                            if (sda_oe)
                            begin
                                state_q <= ssf_pkg::RX_BYTE;
                                bit_q   <= 3'h0;
                                idx_q   <= (idx_q == 2'h3) ? idx_q : idx_q + 2'h1;
                            end
                        end
                    end
                    ssf_pkg::RX_SKIP:
                    begin
                        sda_oe <= 1'b0;
                    end
                    default:
                    begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_ack_only_busy;
        sda_oe |-> rx_busy;
    endproperty
    a_ack_only_busy : assert property (p_ack_only_busy)
        else $error("Slave drives acknowledge while not receiving");

    property p_stop_frees;
        stop_c |=> !rx_busy && !sda_oe;
    endproperty
    a_stop_frees : assert property (p_stop_frees)
        else $error("Slave still busy after stop");

    property p_evt_needs_own;
        evt |-> own_q && rx_busy;
    endproperty
    a_evt_needs_own : assert property (p_evt_needs_own)
        else $error("Event match without own address");

    c_shadow_hit : cover property (hit1 || hit2);

endmodule : ssf_slave_rx

// File: design/ssf_status.sv
// Host and slave status registers of the two-wire bus controller
// What this block does
// - Decode registers at config-held I/O base
// - Abort sets transaction-failed flag, bit four
// - Collision ending transaction sets bit three
// - Bad command, unclaimed, time-out set bit two
// - Successful completion sets command-done bit one
// - Flags set by hardware, cleared writing one
// - Host bit zero reads busy, read-only
// - Alert pin sets bit five when enabled
// - Second shadow address match sets bit four
// - First shadow address match sets bit three
// - Command and data match set bit two
// - Slave bit zero reads receiving, read-only
// - Slave flags raise interrupt and resume event
// - Abort stops transaction, flags, routed interrupt
// - Completion interrupt only while enable is set
// - Control bit six launches the command
`timescale 1ns/1ps
`include "ssf_map.svh"

module ssf_status #(
    parameter int IO_AW = 16
) (
    input  wire logic             clk,                        // System clock, 250 MHz
    input  wire logic             arst_n,                     // Async reset
    input  wire logic             cfg_wr,                     // Config dword write strobe
    input  wire logic [7:0]       cfg_addr,                   // Config dword offset
    input  wire logic [31:0]      cfg_wdata,                  // Config write data
    input  wire logic [IO_AW-1:0] io_addr,                    // I/O byte address
    input  wire logic             io_rd,                      // I/O read strobe
    input  wire logic             io_wr,                      // I/O write strobe
    input  wire logic [7:0]       io_wdata,                   // I/O write data
    output logic      [7:0]       io_rdata,                   // I/O read data
    output logic                  io_claim,                   // Address hits one of the three registers
    output logic                  host_start,                 // Pulse: launch command
    output logic                  host_kill,                  // Level: abort control
    output logic      [2:0]       host_protocol,              // Command protocol field
    input  wire logic             host_done,                  // Pulse: command completed
    input  wire logic             host_device_error_flag,               // Pulse: device error
    input  wire logic             host_collision,             // Pulse: bus collision
    input  wire logic             smb_clk_pin,                // Bus clock pin
    input  wire logic             smb_data_pin_i,             // Bus data pin level
    output logic                  smb_data_pin_o,             // Bus data pin output
    output logic                  smb_data_pin_oe,            // Bus data pin enable
    input  wire logic             smb_alert_n_pin,            // Alert pin, active low
    input  wire logic             alert_wake_enable,          // Alert flag enable
    input  wire logic             irq_route_select,           // 0: irq line, 1: smi line
    input  wire logic [6:0]       shadow_address_port1,       // First shadow address
    input  wire logic [6:0]       shadow_address_port2,       // Second shadow address
    input  wire logic [6:0]       slave_own_addr,             // Own slave address
    input  wire logic [7:0]       slave_command_match_value,  // Command match value
    input  wire logic [7:0]       slave_data_event_pattern,   // Data event pattern
    output logic                  completion_irq_line,        // Routed interrupt, level
    output logic                  smi_line,                   // Alternate route, level
    output logic                  resume_event                // Slave resume request, level
);

    if (IO_AW < `SSF_IO_WIN_BITS + 1 || IO_AW > 32)
    begin : g_bad_width
        $error("IO_AW out of range");
    end

    logic [31:0]      cfg_base_q;
    logic [7:0]       hs_q;
    logic [7:0]       ss_q;
    logic [7:0]       hc_q;
    logic             busy_q;
    logic [2:0]       pin_sync;
    logic             rx_busy;
    logic             hit1;
    logic             hit2;
    logic             evt;
    logic             wr_hs;
    logic             wr_ss;
    logic             wr_hc;
    logic             launch;
    logic             abort;
    logic             finish;
    logic             cause_d;
    logic [7:0]       hs_view;
    logic [7:0]       ss_view;

    // Offset match inside the window programmed by configuration
    function automatic logic io_hit(input logic [IO_AW-1:0] addr,
                                    input logic [31:0] base,
                                    input logic [3:0] ofs);
        io_hit = (addr[IO_AW-1:`SSF_IO_WIN_BITS] == base[IO_AW-1:`SSF_IO_WIN_BITS])
            && (addr[`SSF_IO_WIN_BITS-1:0] == ofs);
    endfunction : io_hit

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_base_q <= `SSF_CFG_RESET;
        end
        else if (cfg_wr && cfg_addr == `SSF_CFG_BASE_OFS)
        begin
            cfg_base_q <= cfg_wdata;
        end
    end

    assign wr_hs = io_wr && io_hit(io_addr, cfg_base_q, `SSF_HSTS_OFS);
    assign wr_ss = io_wr && io_hit(io_addr, cfg_base_q, `SSF_SSTS_OFS);
    assign wr_hc = io_wr && io_hit(io_addr, cfg_base_q, `SSF_HCTL_OFS);
    assign io_claim = io_hit(io_addr, cfg_base_q, `SSF_HSTS_OFS)
        || io_hit(io_addr, cfg_base_q, `SSF_SSTS_OFS)
        || io_hit(io_addr, cfg_base_q, `SSF_HCTL_OFS);

    // A launch while busy or aborting is dropped; software must poll busy first
    assign launch = wr_hc && io_wdata[`SSF_HC_START] && !busy_q
        && !io_wdata[`SSF_HC_KILL];
    assign abort  = wr_hc && io_wdata[`SSF_HC_KILL];
    assign finish = host_done || host_device_error_flag || host_collision;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hc_q <= `SSF_HC_RESET;
        end
        else if (wr_hc)
        begin
            // Start is a strobe and never stored
            hc_q <= io_wdata & `SSF_HC_RW_MASK;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            host_start <= 1'b0;
        end
        else
        begin
            host_start <= launch;
        end
    end

    assign host_kill     = hc_q[`SSF_HC_KILL];
    assign host_protocol = hc_q[`SSF_HC_PROT_MSB:`SSF_HC_PROT_LSB];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy_q <= 1'b0;
        end
        else if (abort || (busy_q && finish))
        begin
            busy_q <= 1'b0;
        end
        else if (launch)
        begin
            busy_q <= 1'b1;
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hs_q <= `SSF_STS_RESET;
        end
        else
        begin
            hs_q <= ((hs_q & ~(wr_hs ? io_wdata : 8'h00))
                | {3'b000, abort, busy_q && host_collision,
                   busy_q && host_device_error_flag, busy_q && host_done, 1'b0})
                & `SSF_HS_W1C_MASK;
        end
    end

    ssf_sync #(
        .W (3)
    ) u_pin_sync (
        .clk    (clk),
        .arst_n (arst_n),
        // Alert goes in inverted so the synchroniser's reset zero means idle, not asserted
        .d      ({smb_clk_pin, smb_data_pin_i, !smb_alert_n_pin}),
        .q      (pin_sync)
    );

    ssf_slave_rx u_slave_rx (
        .clk          (clk),
        .arst_n       (arst_n),
        .scl          (pin_sync[2]),
        .sda          (pin_sync[1]),
        .sda_o        (smb_data_pin_o),
        .sda_oe       (smb_data_pin_oe),
        .shadow1_addr (shadow_address_port1),
        .shadow2_addr (shadow_address_port2),
        .own_addr     (slave_own_addr),
        .cmd_match    (slave_command_match_value),
        .data_pattern (slave_data_event_pattern),
        .hit1         (hit1),
        .hit2         (hit2),
        .evt          (evt),
        .rx_busy      (rx_busy)
    );

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ss_q <= `SSF_STS_RESET;
        end
        else
        begin
            ss_q <= ((ss_q & ~(wr_ss ? io_wdata : 8'h00))
                | {2'b00, pin_sync[0] && alert_wake_enable,
                   hit2, hit1, evt, 2'b00})
                & `SSF_SS_W1C_MASK;
        end
    end

    assign hs_view = hs_q | {7'h00, busy_q};
    assign ss_view = ss_q | {7'h00, rx_busy};

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            io_rdata <= 8'h00;
        end
        else if (io_rd)
        begin
            if (io_hit(io_addr, cfg_base_q, `SSF_HSTS_OFS))
            begin
                io_rdata <= hs_view;
            end
            else if (io_hit(io_addr, cfg_base_q, `SSF_SSTS_OFS))
            begin
                io_rdata <= ss_view;
            end
            else if (io_hit(io_addr, cfg_base_q, `SSF_HCTL_OFS))
            begin
                io_rdata <= hc_q;
            end
            else
            begin
                io_rdata <= 8'h00;
            end
        end
    end

    // Abort and error causes interrupt regardless of the enable
    assign cause_d = (hc_q[`SSF_HC_IEN] && hs_q[`SSF_HS_DONE])
        || hs_q[`SSF_HS_FAILED] || hs_q[`SSF_HS_COLL] || hs_q[`SSF_HS_DEVERR]
        || (ss_q != 8'h00);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            completion_irq_line <= 1'b0;
            smi_line            <= 1'b0;
            resume_event        <= 1'b0;
        end
        else
        begin
            completion_irq_line <= cause_d && !irq_route_select;
            smi_line            <= cause_d && irq_route_select;
            resume_event        <= (ss_q != 8'h00);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_launch_busy;
        launch |=> busy_q && host_start ##1 !host_start;
    endproperty
    a_launch_busy : assert property (p_launch_busy)
        else $error("Launch did not set busy for one start pulse");

    property p_abort_fail;
        abort |=> hs_q[`SSF_HS_FAILED] && !busy_q;
    endproperty
    a_abort_fail : assert property (p_abort_fail)
        else $error("Abort did not set failed flag");

    property p_done_with_busy;
        busy_q && host_done && !abort |=> !busy_q && hs_q[`SSF_HS_DONE];
    endproperty
    a_done_with_busy : assert property (p_done_with_busy)
        else $error("Busy and done flag not changed together");

    property p_set_wins;
        busy_q && host_collision && wr_hs && io_wdata[`SSF_HS_COLL] |=> hs_q[`SSF_HS_COLL];
    endproperty
    a_set_wins : assert property (p_set_wins)
        else $error("Collision flag lost to clear");

    property p_clear_one;
        wr_hs && io_wdata[`SSF_HS_DEVERR] && !host_device_error_flag |=> !hs_q[`SSF_HS_DEVERR];
    endproperty
    a_clear_one : assert property (p_clear_one)
        else $error("Write of one did not clear device error");

    property p_zero_keeps;
        ss_q[`SSF_SS_SHDW1] && wr_ss && !io_wdata[`SSF_SS_SHDW1] |=> ss_q[`SSF_SS_SHDW1];
    endproperty
    a_zero_keeps : assert property (p_zero_keeps)
        else $error("Write of zero cleared a flag");

    property p_reserved;
        hs_q[7:5] == 3'b000 && ss_q[7:6] == 2'b00 && ss_q[1] == 1'b0;
    endproperty
    a_reserved : assert property (p_reserved)
        else $error("Reserved status bit set");

    property p_alert_gate;
        $rose(ss_q[`SSF_SS_ALERT]) |-> $past(alert_wake_enable);
    endproperty
    a_alert_gate : assert property (p_alert_gate)
        else $error("Alert flag set while disabled");

    property p_no_irq_off;
        !hc_q[`SSF_HC_IEN] && hs_q == 8'h02 && ss_q == 8'h00
            |=> !completion_irq_line && !smi_line;
    endproperty
    a_no_irq_off : assert property (p_no_irq_off)
        else $error("Completion interrupt while disabled");

    property p_resume;
        ss_q[`SSF_SS_EVENT] |=> resume_event && (completion_irq_line || smi_line);
    endproperty
    a_resume : assert property (p_resume)
        else $error("Slave flag gave no interrupt or resume");

    c_launch_done : cover property (launch ##[1:20] host_done);
    c_abort       : cover property (busy_q && abort);
    c_slave_evt   : cover property ($rose(ss_q[`SSF_SS_EVENT]));

endmodule : ssf_status

// File: design/ssf_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module ssf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,    // System clock
    input  wire logic         arst_n, // Async reset
    input  wire logic [W-1:0] d,      // Asynchronous inputs
    output logic      [W-1:0] q       // Synchronised outputs
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : ssf_sync

// File: include/ssf_map.svh
// Offsets, field positions, reset values and masks of the status flag block
`ifndef SSF_MAP_SVH
`define SSF_MAP_SVH

`define SSF_CFG_BASE_OFS    8'h90
`define SSF_IO_WIN_BITS     4
`define SSF_HSTS_OFS        4'h0
`define SSF_SSTS_OFS        4'h1
`define SSF_HCTL_OFS        4'h2

`define SSF_HS_FAILED       4
`define SSF_HS_COLL         3
`define SSF_HS_DEVERR       2
`define SSF_HS_DONE         1
`define SSF_HS_BUSY         0

`define SSF_SS_ALERT        5
`define SSF_SS_SHDW2        4
`define SSF_SS_SHDW1        3
`define SSF_SS_EVENT        2
`define SSF_SS_RXBUSY       0

`define SSF_HC_START        6
`define SSF_HC_PROT_MSB     4
`define SSF_HC_PROT_LSB     2
`define SSF_HC_KILL         1
`define SSF_HC_IEN          0

`define SSF_HS_W1C_MASK     8'h1E
`define SSF_SS_W1C_MASK     8'h3C
`define SSF_HC_RW_MASK      8'h1F
`define SSF_STS_RESET       8'h00
`define SSF_HC_RESET        8'h00
`define SSF_CFG_RESET       32'h0000_0000

`endif

// File: include/ssf_pkg.sv
// Types shared by the status flag block
package ssf_pkg;

    typedef enum logic [1:0]
    {
        RX_IDLE,
        RX_BYTE,
        RX_ACK,
        RX_SKIP
    } ssf_rx_state_type;

endpackage : ssf_pkg

// File: tb/ssf_bus_master.sv
// Two-wire bus master model sending write frames
`timescale 1ns/1ps

module ssf_bus_master (
    output logic     scl,   // Bus clock, high between frames
    output wire      sda,   // Bus data with pull-up
    input wire logic dev_oe // Device pulls data low
);
    logic sda_m = 1'b1;
    logic addr_ack;
    initial scl = 1'b1;
    // Open drain: a released line floats to the pull-up
    assign sda = sda_m & ~dev_oe;
    task automatic frame(input logic [26:0] bits);
        #31 sda_m = 1'b0;
        #31 scl = 1'b0;
        for (int i = 26; i >= 0; i--)
        begin
            #31 sda_m = bits[i];
            #31 scl = 1'b1;
            if (i == 18) addr_ack = ~sda;
            #63 scl = 1'b0;
        end
        #31 sda_m = 1'b0;
        #31 scl = 1'b1;
        #31 sda_m = 1'b1;
    endtask : frame
endmodule : ssf_bus_master

// File: tb/ssf_status_tb.sv
// Bench: status flag block against a bit-level model
`timescale 1ns/1ps

module ssf_status_tb;
    logic        clk, arst_n, cfg_wr, io_rd, io_wr, host_done, host_device_error_flag, host_collision;
    logic        alert_n, alert_en, route, oe, scl, ien, irq, smi, resume;
    logic [31:0] cfg_wdata;
    logic [15:0] io_addr, base;
    logic [7:0]  io_wdata, io_rdata, hs, ss, cmd, pat;
    logic [6:0]  adr [3];
    wire         sda;
    int          err_total, comparisons;

    ssf_status DUT (.clk, .arst_n, .cfg_wr, .cfg_addr(8'h90), .cfg_wdata, .io_addr, .io_rd,
        .io_wr, .io_wdata, .io_rdata, .io_claim(), .host_start(), .host_kill(),
        .host_protocol(), .host_done, .host_device_error_flag, .host_collision, .smb_clk_pin(scl),
        .smb_data_pin_i(sda), .smb_data_pin_o(), .smb_data_pin_oe(oe),
        .smb_alert_n_pin(alert_n), .alert_wake_enable(alert_en), .irq_route_select(route),
        .shadow_address_port1(adr[0]), .shadow_address_port2(adr[1]),
        .slave_own_addr(adr[2]), .slave_command_match_value(cmd),
        .slave_data_event_pattern(pat), .completion_irq_line(irq), .smi_line(smi),
        .resume_event(resume));
    ssf_bus_master M (.scl, .sda, .dev_oe(oe));
    always #2 clk = ~clk;

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask : chk8
    task automatic complete_run();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // A read compares against d, a write updates the model
    // While busy only host status is polled, apart from the deliberate abort
    task automatic io(input logic w, input logic [1:0] ofs, input logic [7:0] d);
        @(negedge clk);
        {io_wr, io_rd, io_wdata, io_addr} = {w, ~w, d, base + 16'(ofs)};
        @(negedge clk);
        {io_wr, io_rd} = 2'b00;
        if (!w) chk8(io_rdata, d);
        if (w && ofs == 2'd0) hs &= ~(d & 8'h1E);
        if (w && ofs == 2'd1) ss &= ~(d & 8'h3C);
        if (w && ofs == 2'd2) {ien, hs} = {d[0], d[1] ? hs & 8'hFE | 8'h10 : hs | 8'(d[6])};
    endtask : io
    task automatic pulse(input int k);
        @(negedge clk);
        {host_collision, host_device_error_flag, host_done} = 3'(1 << k);
        @(negedge clk);
        {host_collision, host_device_error_flag, host_done} = 3'b000;
        hs = hs & 8'hFE | 8'(2 << k);
    endtask : pulse
    task automatic lines_chk();
        logic any;
        any = (hs & 8'h1C) != 0 || (hs[1] && ien) || (ss & 8'h3C) != 0;
        chk8({irq, smi, resume}, {any & ~route, any & route, (ss & 8'h3C) != 0});
    endtask : lines_chk

    initial
    begin
        {clk, arst_n, cfg_wr, io_rd, io_wr, host_done, host_device_error_flag, host_collision} = '0;
        {cfg_wdata, io_addr, io_wdata, hs, ss, ien, err_total, comparisons} = '0;
        {alert_n, alert_en, route} = 3'b100;
        {adr[0], cmd, pat} = {7'h40 | 7'($urandom(36407)), 16'($urandom) | 16'h0001};
        adr[1:2] = '{adr[0] ^ 7'h01, adr[0] ^ 7'h02};
        base = 16'($urandom) & 16'hFFF0;
        repeat (12) @(negedge clk);
        {arst_n, cfg_wr, cfg_wdata} = {2'b11, 16'h0000, base};
        @(negedge clk);
        cfg_wr = 1'b0;
        io(0, 0, 8'h00);
        io(0, 1, 8'h00);
        for (int k = 0; k < 5; k++)
        begin
            route = 1'($urandom);
            io(1, 0, 8'hE1);
            io(0, 0, hs);
            io(1, 0, 8'h1E);
            io(1, 2, {7'h20, k == 0});
            io(0, 0, 8'h01);
            if (k == 3)
                io(1, 2, 8'h42);
            else
                pulse(k % 4);
            io(0, 0, hs);
            io(0, 2, (k == 3) ? 8'h02 : 8'(k == 0));
            lines_chk();
        end
        alert_n = 1'b0;
        repeat (6) @(negedge clk);
        io(0, 1, 8'h00);
        {alert_en, ss} = {1'b1, 8'h20};
        repeat (6) @(negedge clk);
        io(0, 1, ss);
        lines_chk();
        {alert_n, alert_en} = 2'b10;
        repeat (6) @(negedge clk);
        io(1, 1, 8'h20);
        for (int k = 0; k < 3; k++)
        begin
            M.frame({adr[k], 2'b01, cmd, 1'b1, pat, 1'b1});
            ss = (k == 2) ? 8'h04 : 8'(8'h08 << k);
            repeat (6) @(negedge clk);
            chk8({7'h00, M.addr_ack}, 8'h01);
            io(0, 1, ss);
            lines_chk();
            io(1, 1, 8'h3C);
        end
        complete_run();
    end

    initial
    begin
        #100000;
        err_total++;
        complete_run();
    end
endmodule : ssf_status_tb
